/* File: rtl/dsd_pkg.sv */
package dsd_pkg;

  // Serial word format on the link
  localparam int WORD_BITS = 18;

  // Clock rates
  localparam int CLK_HZ      = 10_000_000;
  localparam int LINK_MAX_HZ = 13_500_000;

  // Half period of the derived bit clock, rounded up so the link never runs too fast
  localparam int BIT_HALF_CYCLES_RAW = (CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
  localparam int BIT_HALF_CYCLES     = (BIT_HALF_CYCLES_RAW < 1) ? 1 : BIT_HALF_CYCLES_RAW;

  // Word update rates as multiples of the base sample rate; at CLK_HZ the link is fast enough only for the 2 and 4 multiples
  localparam int BASE_RATE_HZ = 44_100;
  localparam int RATE_MULT_2  = 2;
  localparam int RATE_MULT_4  = 4;
  localparam int RATE_MULT_8  = 8;
  localparam int RATE_MULT_16 = 16;

  // Reset and idle values, and the word period counter width
  localparam logic STROBE_IDLE       = 1'b1;
  localparam logic SERIAL_IDLE       = 1'b0;
  localparam logic BIT_CLK_RESET     = 1'b0;
  localparam int   PERIOD_WIDTH      = 16;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 18'h00000;

  // Clk cycles allowed between left and right updates to count as one joint event
  localparam int JOINT_WINDOW_CYCLES = 4;

  typedef logic [WORD_BITS-1:0] dsd_word_t;

endpackage

/* File: rtl/dsd_link_if.sv */
`timescale 1ns/100ps
interface dsd_link_if;
  logic bit_clk;
  logic left_serial_in;
  logic right_serial_in;
  logic left_update_strobe;
  logic right_update_strobe;

  modport filter (
    output bit_clk,
    output left_serial_in,
    output right_serial_in,
    output left_update_strobe,
    output right_update_strobe
  );

  modport dac (
    input bit_clk,
    input left_serial_in,
    input right_serial_in,
    input left_update_strobe,
    input right_update_strobe
  );
endinterface

/* File: rtl/dsd_channel_in.sv */
`timescale 1ns/100ps
module dsd_channel_in #(
  parameter int WIDTH = dsd_pkg::WORD_BITS
) (
  input  wire logic             bit_clk,
  input  wire logic             reset,
  input  wire logic             serial_in,
  input  wire logic             update_strobe,
  output logic [WIDTH-1:0]      latch_word,
  output logic                  update_toggle
);
  import dsd_pkg::*;

  logic [WIDTH-1:0] shift_word;
  logic             strobe_prev;
  wire              strobe_fall = strobe_prev & ~update_strobe;

  // Shift on every rising bit clock edge, MSB arrives first
  always_ff @(posedge bit_clk or posedge reset) begin
    if (reset) begin
      shift_word <= '0;
    end else begin
      shift_word <= {shift_word[WIDTH-2:0], serial_in};
    end
  end

  // Latch takes the word as it stood before this edge's shift
  always_ff @(posedge bit_clk or posedge reset) begin
    if (reset) begin
      strobe_prev   <= STROBE_IDLE;
      latch_word    <= WORD_RESET;
      update_toggle <= 1'b0;
    end else begin
      strobe_prev <= update_strobe;
      if (strobe_fall) begin
        latch_word    <= shift_word;
        update_toggle <= ~update_toggle;
      end
    end
  end
endmodule

/* File: rtl/dsd_dac_end.sv */
`timescale 1ns/100ps
module dsd_dac_end #(
  parameter int WIDTH    = dsd_pkg::WORD_BITS,
  parameter int PERIOD_W = dsd_pkg::PERIOD_WIDTH
) (
  input  wire logic            clk,
  input  wire logic            reset,
  dsd_link_if.dac              link,
  output dsd_pkg::dsd_word_t   left_sample,
  output dsd_pkg::dsd_word_t   right_sample,
  output logic                 left_updated,
  output logic                 right_updated,
  output logic                 joint_update,
  output logic [PERIOD_W-1:0]  word_period,
  output logic                 link_active
);
  import dsd_pkg::*;

  localparam int NUM_CH = 2;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = '1;
  localparam logic [2:0] JOINT_LIMIT = 3'(JOINT_WINDOW_CYCLES);
  localparam logic [3:0] IDLE_LIMIT  = 4'hf;

  // Link domain: both channels run off the one bit clock pin
  logic [WIDTH-1:0] latch_word [NUM_CH];
  logic [NUM_CH-1:0] update_toggle;
  logic              link_heartbeat;

  dsd_channel_in #(
    .WIDTH (WIDTH)
  ) u_left (
    .bit_clk       (link.bit_clk),
    .reset         (reset),
    .serial_in     (link.left_serial_in),
    .update_strobe (link.left_update_strobe),
    .latch_word    (latch_word[0]),
    .update_toggle (update_toggle[0])
  );

  dsd_channel_in #(
    .WIDTH (WIDTH)
  ) u_right (
    .bit_clk       (link.bit_clk),
    .reset         (reset),
    .serial_in     (link.right_serial_in),
    .update_strobe (link.right_update_strobe),
    .latch_word    (latch_word[1]),
    .update_toggle (update_toggle[1])
  );

  // Divides the bit clock so the system side can tell the link is running
  always_ff @(posedge link.bit_clk or posedge reset) begin
    if (reset) begin
      link_heartbeat <= 1'b0;
    end else begin
      link_heartbeat <= ~link_heartbeat;
    end
  end

  // Clock domain crossing of update events: toggle plus stable data.
  // The latch holds for at least a whole word of bit clocks after each
  // toggle, far longer than the synchroniser delay, so sampling it on the
  // synchronised edge is safe.
  logic [NUM_CH-1:0] tog_meta;
  logic [NUM_CH-1:0] tog_sync;
  logic [NUM_CH-1:0] tog_seen;
  wire  [NUM_CH-1:0] update_evt = tog_sync ^ tog_seen;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tog_meta <= '0;
      tog_sync <= '0;
      tog_seen <= '0;
    end else begin
      tog_meta <= update_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  dsd_word_t sample_q [NUM_CH];
  logic [NUM_CH-1:0] updated_q;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_cap
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sample_q[ch]  <= WORD_RESET;
          updated_q[ch] <= 1'b0;
        end else begin
          updated_q[ch] <= update_evt[ch];
          if (update_evt[ch]) begin
            sample_q[ch] <= latch_word[ch];
          end
        end
      end
    end
  endgenerate

  assign left_sample   = sample_q[0];
  assign right_sample  = sample_q[1];
  assign left_updated  = updated_q[0];
  assign right_updated = updated_q[1];

  // Joint update: both channels seen within a short window of each other.
  // Synchroniser skew may split a shared strobe by a cycle, hence the window.
  logic [2:0] since_left;
  logic [2:0] since_right;
  logic       joint_q;
  wire        left_recent  = (since_left  < JOINT_LIMIT);
  wire        right_recent = (since_right < JOINT_LIMIT);
  wire        joint_hit    = (update_evt[0] & (update_evt[1] | right_recent))
                           | (update_evt[1] & left_recent);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_left  <= JOINT_LIMIT;
      since_right <= JOINT_LIMIT;
      joint_q     <= 1'b0;
    end else begin
      since_left  <= update_evt[0] ? 3'h0 : (left_recent  ? since_left  + 3'h1 : since_left);
      since_right <= update_evt[1] ? 3'h0 : (right_recent ? since_right + 3'h1 : since_right);
      joint_q     <= joint_hit;
    end
  end

  assign joint_update = joint_q;

  // Word period in clk cycles, measured on the left channel; the port does
  // not care which oversampling rate the sender uses, this only reports it.
  logic [PERIOD_W-1:0] period_cnt;
  logic [PERIOD_W-1:0] period_q;
  wire                 period_sat = (period_cnt == PERIOD_MAX);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      period_cnt <= '0;
      period_q   <= '0;
    end else begin
      if (update_evt[0]) begin
        period_q   <= period_cnt;
        period_cnt <= '0;
      end else if (!period_sat) begin
        period_cnt <= period_cnt + 1'b1;
      end
    end
  end

  assign word_period = period_q;

  // Link activity from the synchronised bit clock heartbeat
  logic       beat_meta;
  logic       beat_sync;
  logic       beat_seen;
  logic [3:0] idle_cnt;
  logic       active_q;
  wire        beat_evt  = beat_sync ^ beat_seen;
  wire        idle_full = (idle_cnt == IDLE_LIMIT);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      beat_meta <= 1'b0;
      beat_sync <= 1'b0;
      beat_seen <= 1'b0;
    end else begin
      beat_meta <= link_heartbeat;
      beat_sync <= beat_meta;
      beat_seen <= beat_sync;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_cnt <= IDLE_LIMIT;
      active_q <= 1'b0;
    end else begin
      if (beat_evt) begin
        idle_cnt <= 4'h0;
      end else if (!idle_full) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
      active_q <= ~idle_full;
    end
  end

  assign link_active = active_q;

endmodule

/* File: rtl/dsd_filter_end.sv */
`timescale 1ns/100ps
module dsd_filter_end #(
  parameter int WIDTH       = dsd_pkg::WORD_BITS,
  parameter int HALF_CYCLES = dsd_pkg::BIT_HALF_CYCLES
) (
  input  wire logic           clk,
  input  wire logic           reset,
  dsd_link_if.filter          link,
  input  dsd_pkg::dsd_word_t  left_word,
  input  dsd_pkg::dsd_word_t  right_word,
  input  wire logic           word_valid,
  output logic                word_ready,
  input  wire logic           mono_mode,
  output logic                busy
);
  import dsd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_LATCH = 3'b100
  } dsd_fstate_t;

  localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYCLES - 1);
  localparam logic [4:0]    BIT_LAST  = 5'(WORD_BITS - 1);

  dsd_fstate_t      state;
  logic [CW-1:0]    half_cnt;
  logic             bit_clk_q;
  logic [4:0]       bit_cnt;
  logic [WIDTH-1:0] left_sh;
  logic [WIDTH-1:0] right_sh;
  logic             word_clock_q;

  // Bit clock derived from clk; data and strobe move on its falling edges
  wire half_done = (half_cnt == HALF_LAST);
  wire fall_evt  = half_done & bit_clk_q;
  wire can_load  = (state == ST_IDLE) | (state == ST_LATCH);
  wire take      = fall_evt & can_load & word_valid;
  wire last_bit  = (bit_cnt == BIT_LAST);

  assign word_ready = fall_evt & can_load;
  assign busy       = (state != ST_IDLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_cnt  <= '0;
      bit_clk_q <= BIT_CLK_RESET;
    end else begin
      half_cnt <= half_done ? '0 : half_cnt + 1'b1;
      if (half_done) begin
        bit_clk_q <= ~bit_clk_q;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= ST_IDLE;
      bit_cnt      <= '0;
      left_sh      <= WORD_RESET;
      right_sh     <= WORD_RESET;
      word_clock_q <= STROBE_IDLE;
    end else if (fall_evt) begin
      unique case (state)
        ST_IDLE, ST_LATCH: begin
          word_clock_q <= STROBE_IDLE;
          if (take) begin
            left_sh  <= left_word;
            right_sh <= mono_mode ? left_word : right_word;
            bit_cnt  <= '0;
            state    <= ST_SHIFT;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          if (last_bit) begin
            word_clock_q <= ~STROBE_IDLE;
            state        <= ST_LATCH;
          end else begin
            left_sh  <= {left_sh[WIDTH-2:0], SERIAL_IDLE};
            right_sh <= {right_sh[WIDTH-2:0], SERIAL_IDLE};
            bit_cnt  <= bit_cnt + 5'h1;
          end
        end
      endcase
    end
  end

  wire filter_word_clock_out = word_clock_q;

  assign link.bit_clk             = bit_clk_q;
  assign link.left_serial_in      = left_sh[WIDTH-1];
  assign link.right_serial_in     = right_sh[WIDTH-1];
  assign link.left_update_strobe  = filter_word_clock_out;
  assign link.right_update_strobe = filter_word_clock_out;

endmodule

/* File: test/dsd_link_sva.sv */
`timescale 1ns/100ps
module dsd_link_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic bit_clk,
  input wire logic left_serial_in,
  input wire logic right_serial_in,
  input wire logic left_update_strobe,
  input wire logic right_update_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Clk cycles since the last strobe fall; saturates so idle never wraps
  logic [7:0] gap;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap <= 8'hff;
    end else if ($fell(left_update_strobe)) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  chk_strobes_tied: assert property (left_update_strobe == right_update_strobe)
    else $error("latch strobes differ");
  chk_bit_rise: assert property (!bit_clk |=> bit_clk)
    else $error("bit clock missed a rise");
  chk_bit_fall: assert property (bit_clk |=> !bit_clk)
    else $error("bit clock missed a fall");
  chk_strobe_edge: assert property ($fell(left_update_strobe) |-> $fell(bit_clk))
    else $error("strobe fell off a bit clock fall");
  chk_strobe_width: assert property ($fell(left_update_strobe) |=> !left_update_strobe ##1
                                     left_update_strobe)
    else $error("strobe low width wrong");
  chk_data_edge: assert property (($changed(left_serial_in) || $changed(right_serial_in))
                                  |-> $fell(bit_clk))
    else $error("data moved off a bit clock fall");
  chk_data_quiet: assert property (!left_update_strobe |-> $stable(left_serial_in) &&
                                   $stable(right_serial_in))
    else $error("data moved during strobe");
  chk_word_spacing: assert property ($fell(left_update_strobe) |-> gap >= 8'h25)
    else $error("words closer than nineteen bit periods");
endmodule

/* File: test/test_dual_serial_dac_input_port.sv */
`timescale 1ns/100ps
module test_dual_serial_dac_input_port;
  import dsd_pkg::*;
  localparam int BIT_CLKS = 2 * BIT_HALF_CYCLES;

  logic        clk          = 1'b0;
  logic        reset        = 1'b0;
  dsd_word_t   left_word    = '0;
  dsd_word_t   right_word   = '0;
  logic        word_valid   = 1'b0;
  logic        mono_mode    = 1'b0;
  logic        word_ready;
  logic        busy;
  dsd_word_t   left_sample;
  dsd_word_t   right_sample;
  logic        left_updated;
  logic        right_updated;
  logic        joint_update;
  logic [15:0] word_period;
  logic        link_active;
  logic        seen_l;
  logic        seen_r;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  dsd_word_t   pat [4]      = '{18'h20000, 18'h1ffff, 18'h00001, 18'h2aaaa};

  dsd_link_if link ();

  dsd_filter_end u_dsd_filter_end (.clk, .reset, .link(link), .left_word, .right_word,
                                   .word_valid, .word_ready, .mono_mode, .busy);
  dsd_dac_end u_dsd_dac_end (.clk, .reset, .link(link), .left_sample, .right_sample,
                             .left_updated, .right_updated, .joint_update, .word_period,
                             .link_active);
  dsd_link_sva u_dsd_link_sva (.clk, .reset, .bit_clk(link.bit_clk),
                               .left_serial_in(link.left_serial_in),
                               .right_serial_in(link.right_serial_in),
                               .left_update_strobe(link.left_update_strobe),
                               .right_update_strobe(link.right_update_strobe));

  always #50 clk = ~clk;

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A spare negedge first, so valid never drops and rises in one step
  task automatic send(input dsd_word_t l, input dsd_word_t r, input logic mono);
    @(negedge clk);
    left_word = l;
    right_word = r;
    mono_mode = mono;
    word_valid = 1'b1;
    #1;
    while (word_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    word_valid = 1'b0;
  endtask

  task automatic wait_update;
    seen_l = 1'b0;
    seen_r = 1'b0;
    do begin
      @(negedge clk);
      seen_l = seen_l | left_updated;
      seen_r = seen_r | right_updated;
    end while (joint_update !== 1'b1);
    check(18'(seen_l), 18'h00001);
    check(18'(seen_r), 18'h00001);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict;
    end
  end

  initial begin
    // Raised after a zero delay, still at time zero, so the bit clock flops see a reset edge too
    #0 reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(left_sample, WORD_RESET);
    for (int i = 0; i < 4; i++) begin
      send(pat[i], ~pat[i], 1'b0);
      check(18'(busy), 18'h00001);
      wait_update;
      check(left_sample, pat[i]);
      check(right_sample, ~pat[i]);
      check(18'(busy), 18'h00000);
    end
    send(18'h12345, 18'h0abcd, 1'b1);
    wait_update;
    check(right_sample, 18'h12345);
    check(left_sample, 18'h12345);
    // Idle link: latches must hold while the bit clock keeps running
    repeat (40) @(negedge clk);
    check(left_sample, 18'h12345);
    check(right_sample, 18'h12345);
    check(18'(link_active), 18'h00001);
    // Back to back at the tightest spacing the sender allows
    send(18'h3c00f, 18'h00ff0, 1'b0);
    send(18'h03ff0, 18'h3f00f, 1'b0);
    // First word lands while the second is still shifting
    wait_update;
    check(left_sample, 18'h3c00f);
    check(right_sample, 18'h00ff0);
    wait_update;
    check(left_sample, 18'h03ff0);
    check(right_sample, 18'h3f00f);
    // Period counter restarts at zero on the update edge itself
    check(18'(word_period), 18'((WORD_BITS + 1) * BIT_CLKS - 1));
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check(left_sample, WORD_RESET);
    check(18'(link_active), 18'h00000);
    reset = 1'b0;
    send(18'h2468a, 18'h13579, 1'b0);
    wait_update;
    check(left_sample, 18'h2468a);
    check(right_sample, 18'h13579);
    give_verdict;
  end
endmodule
